/* File: rtl/reset_strap_sampler.sv */
// Strap sampler with AXI4-Lite control of the test and focus motor pins.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns

// Function
// - Sample straps at release, then drive pins
// - Open pin reads low, default configuration
// - Focus mode: pin 0 is chip enable
// - Focus mode: pins 1-4 are data, LSB first
// - Pin 4 low: auto initialize from flash
// - Pin 4 high: skip init, allow programming
// - Pin 6 low: reference clock 16.67 MHz
// - Pin 6 high: reference clock 8.33 MHz
module reset_strap_sampler
    import strap_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic [STRAP_PINS-1:0] strap_pin_in,
    output logic      [STRAP_PINS-1:0] strap_pin_out,
    output logic      [STRAP_PINS-1:0] strap_pin_oe,
    output logic                       straps_valid,
    output logic                       test_mode_request,
    output logic                       flash_auto_init,
    output logic                       flash_program_enable,
    output logic      [15:0]           pll_ref_khz,
    input  wire logic [ADDR_W-1:0]     awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic      [1:0]            bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [ADDR_W-1:0]     araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic      [31:0]           rdata,
    output logic      [1:0]            rresp,
    output logic                       rvalid,
    input  wire logic                  rready
);

    // ------------------------------------------------------------------
    // Strap capture sequence
    // ------------------------------------------------------------------
    strap_state_t          state;
    strap_state_t          next_state;
    strap_cfg_t            cfg;
    strap_cfg_t            next_cfg;
    logic                  next_valid;
    logic [15:0]           next_khz;
    logic                  sample;
    logic [STRAP_PINS-1:0] latched;
    logic [STRAP_PINS-1:0] pin_drive;
    ctrl_t                 ctrl;

    assign sample = (state == ST_WAIT);

    always_comb begin
        next_state = state;
        next_cfg   = cfg;
        next_valid = straps_valid;
        next_khz   = pll_ref_khz;
        case (state)
            ST_WAIT: begin
                // The only capture happens here; nothing later reloads cfg.
                next_state              = ST_RUN;
                next_valid              = 1'b1;
                next_cfg.test_mode      = |(strap_pin_in & TEST_MODE_MASK);
                next_cfg.auto_init      = ~strap_pin_in[FLASH_SKIP_PIN];
                next_cfg.flash_program  = strap_pin_in[FLASH_SKIP_PIN];
                next_cfg.pll_reference_clock_half    = strap_pin_in[PLL_REFERENCE_CLOCK_SEL_PIN];
                next_khz                = strap_pin_in[PLL_REFERENCE_CLOCK_SEL_PIN] ? PLL_REFERENCE_CLOCK_HIGH_KHZ
                                                                       : PLL_REFERENCE_CLOCK_LOW_KHZ;
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
    end

    // Reset values equal the all-low strap selection.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= ST_WAIT;
            cfg          <= CFG_RESET;
            straps_valid <= 1'b0;
            pll_ref_khz  <= PLL_REFERENCE_CLOCK_LOW_KHZ;
        end else begin
            state        <= next_state;
            cfg          <= next_cfg;
            straps_valid <= next_valid;
            pll_ref_khz  <= next_khz;
        end
    end

    assign test_mode_request    = cfg.test_mode;
    assign flash_auto_init      = cfg.auto_init;
    assign flash_program_enable = cfg.flash_program;

    // ------------------------------------------------------------------
    // Pin drive selection
    // ------------------------------------------------------------------
    always_comb begin
        pin_drive = ctrl.test_out;
        if (ctrl.focus_enable) begin
            pin_drive[FOCUS_CE_PIN]                          = ctrl.motor_chip_enable;
            pin_drive[FOCUS_DATA_LSB +: FOCUS_DATA_W]        = ctrl.motor_data;
        end
    end

    for (genvar i = 0; i < STRAP_PINS; i++) begin : g_pin
        strap_pin_cell u_cell (
            .ref_clk     (ref_clk),
            .reset_n     (reset_n),
            .sample      (sample),
            .drive_value (pin_drive[i]),
            .pin_in      (strap_pin_in[i]),
            .latched     (latched[i]),
            .pin_out     (strap_pin_out[i]),
            .pin_oe      (strap_pin_oe[i])
        );
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic              aw_held;
    logic              next_aw_held;
    logic              w_held;
    logic              next_w_held;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] next_waddr;
    logic [31:0]       wword;
    logic [31:0]       next_wword;
    logic [3:0]        wmask;
    logic [3:0]        next_wmask;
    ctrl_t             next_ctrl;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_awready;
    logic              next_wready;
    logic              next_rvalid;
    logic [1:0]        next_rresp;
    logic [31:0]       next_rdata;
    logic              next_arready;
    logic [31:0]       merged;
    logic [31:0]       status_word;

    always_comb begin
        status_word                                    = 32'h0;
        status_word[ST_LATCHED_LSB +: STRAP_PINS]      = latched;
        status_word[ST_VALID_BIT]                      = straps_valid;
        status_word[ST_TEST_BIT]                       = cfg.test_mode;
        status_word[ST_AUTO_BIT]                       = cfg.auto_init;
        status_word[ST_PROG_BIT]                       = cfg.flash_program;
        status_word[ST_REFHALF_BIT]                    = cfg.pll_reference_clock_half;
    end

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_waddr   = waddr;
        next_wword   = wword;
        next_wmask   = wmask;
        next_ctrl    = ctrl;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        merged       = {{(32-CTRL_BITS){1'b0}}, ctrl};
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_waddr   = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_wword  = wdata;
            next_wmask  = wstrb;
        end
        // Address and data may arrive in either order; the write waits for both.
        if (next_aw_held && next_w_held) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (next_waddr[7:0] == CTRL_OFFSET) begin
                for (int b = 0; b < 4; b++) begin
                    if (next_wmask[b]) begin
                        merged[8*b +: 8] = next_wword[8*b +: 8];
                    end
                end
                next_ctrl = ctrl_t'(merged[CTRL_BITS-1:0]);
            end else if (next_waddr[7:0] != STATUS_OFFSET) begin
                next_bresp = RESP_SLVERR;
            end
        end
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready  = ~next_w_held & ~next_bvalid;
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = 32'h0;
            if (araddr[7:0] == CTRL_OFFSET) begin
                next_rdata = {{(32-CTRL_BITS){1'b0}}, ctrl};
            end else if (araddr[7:0] == STATUS_OFFSET) begin
                next_rdata = status_word;
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            waddr   <= '0;
            wword   <= 32'h0;
            wmask   <= 4'h0;
            ctrl    <= CTRL_RESET;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            awready <= 1'b1;
            wready  <= 1'b1;
            rvalid  <= 1'b0;
            rresp   <= RESP_OKAY;
            rdata   <= 32'h0;
            arready <= 1'b1;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            waddr   <= next_waddr;
            wword   <= next_wword;
            wmask   <= next_wmask;
            ctrl    <= next_ctrl;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            awready <= next_awready;
            wready  <= next_wready;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            arready <= next_arready;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_capture;
        state == ST_WAIT;
    endsequence

    sequence s_running;
        state == ST_RUN && straps_valid;
    endsequence

    a_capture_drive: assert property (s_capture |=> s_running and (strap_pin_oe == '1
                                      && latched == $past(strap_pin_in)))
        else $error("strap pins not latched and driven after release");

    a_open_default: assert property (s_capture and strap_pin_in == '0 |=>
                                     flash_auto_init && !test_mode_request && pll_ref_khz == 16'h411e)
        else $error("all-low straps did not give default configuration");

    a_focus_enable: assert property (ctrl.focus_enable && strap_pin_oe[0] |=>
                                     strap_pin_out[0] == $past(ctrl.motor_chip_enable))
        else $error("pin 0 does not follow motor chip enable");

    a_focus_data: assert property (ctrl.focus_enable && strap_pin_oe[1] |=>
                                   strap_pin_out[4:1] == $past(ctrl.motor_data))
        else $error("pins 1 to 4 do not follow motor data");

    a_auto_init: assert property (s_capture and !strap_pin_in[4] |=>
                                  flash_auto_init && !flash_program_enable)
        else $error("pin 4 low did not select flash auto init");

    a_flash_prog: assert property (s_capture and strap_pin_in[4] |=>
                                   !flash_auto_init && flash_program_enable)
        else $error("pin 4 high did not select flash programming");

    a_pll_reference_clock_low: assert property (s_capture and !strap_pin_in[6] |=> pll_ref_khz == 16'h411e)
        else $error("pin 6 low did not select 16.67 MHz");

    a_pll_reference_clock_high: assert property (s_capture and strap_pin_in[6] |=> pll_ref_khz == 16'h208a)
        else $error("pin 6 high did not select 8.33 MHz");

    a_straps_hold: assert property (s_running |=> $stable(latched) && $stable(cfg)
                                    && $stable(pll_ref_khz) && state == ST_RUN)
        else $error("latched straps changed after capture");

endmodule : reset_strap_sampler

/* File: rtl/strap_pkg.sv */
// Shared constants and types for the reset strap sampler.
package strap_pkg;

    // ------------------------------------------------------------------
    // Pin set and strap positions
    // ------------------------------------------------------------------
    localparam int          STRAP_PINS        = 7;
    localparam int          FOCUS_CE_PIN      = 0;
    localparam int          FOCUS_DATA_LSB    = 1;
    localparam int          FOCUS_DATA_W      = 4;
    localparam int          FLASH_SKIP_PIN    = 4;
    localparam int          PLL_REFERENCE_CLOCK_SEL_PIN    = 6;
    localparam logic [6:0]  TEST_MODE_MASK    = 7'h2f;

    // ------------------------------------------------------------------
    // Reference clock assumptions, in kHz
    // ------------------------------------------------------------------
    localparam logic [15:0] PLL_REFERENCE_CLOCK_LOW_KHZ    = 16'h411e;
    localparam logic [15:0] PLL_REFERENCE_CLOCK_HIGH_KHZ   = 16'h208a;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
    localparam int          CTRL_BITS         = 13;
    localparam int          ST_LATCHED_LSB    = 0;
    localparam int          ST_VALID_BIT      = 8;
    localparam int          ST_TEST_BIT       = 9;
    localparam int          ST_AUTO_BIT       = 10;
    localparam int          ST_PROG_BIT       = 11;
    localparam int          ST_REFHALF_BIT    = 12;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_RUN  = 1'b1
    } strap_state_t;

    typedef struct packed {
        logic [6:0] test_out;
        logic [3:0] motor_data;
        logic       motor_chip_enable;
        logic       focus_enable;
    } ctrl_t;

    typedef struct packed {
        logic test_mode;
        logic auto_init;
        logic flash_program;
        logic pll_reference_clock_half;
    } strap_cfg_t;

    localparam ctrl_t       CTRL_RESET        = '{default: 1'b0};
    localparam strap_cfg_t  CFG_RESET         = '{test_mode: 1'b0, auto_init: 1'b1,
                                                  flash_program: 1'b0, pll_reference_clock_half: 1'b0};

endpackage : strap_pkg

/* File: rtl/strap_pin_cell.sv */
// One strap pin: sampled once after reset release, then driven.
`timescale 1ns/1ns
module strap_pin_cell (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic sample,
    input  wire logic drive_value,
    input  wire logic pin_in,
    output logic      latched,
    output logic      pin_out,
    output logic      pin_oe
);
    logic next_latched;
    logic next_out;
    logic next_oe;

    always_comb begin
        next_latched = sample ? pin_in : latched;
        next_oe      = pin_oe | sample;
        next_out     = next_oe ? drive_value : 1'b0;
    end

    // The pad is an input while reset holds, so the pulldown decides an open pin.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            latched <= 1'b0;
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            latched <= next_latched;
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

endmodule : strap_pin_cell

/* File: sim/strap_board_model.sv */
// Board strap resistors and focus motor driver on the far side of the strap pins.
`timescale 1ns/1ns
module strap_board_model (
    input  wire logic [6:0] pull_mask,
    input  wire logic [6:0] pin_out,
    input  wire logic [6:0] pin_oe,
    output logic      [6:0] pad,
    output logic      [3:0] motor_word,
    output logic            motor_ce
);
    // --------------------------------------------------------------
    // Pad levels
    // --------------------------------------------------------------
    // A pin that nobody drives settles to its resistor: an external pullup where one is
    // fitted, the weak internal pulldown otherwise. Pullups on test pins are fitted when a scenario
    // asks for a test mode on purpose and wherever a random strap fit sets them.
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pad[i] = pin_oe[i] ? pin_out[i] : pull_mask[i];
        end
    end

    // --------------------------------------------------------------
    // Focus motor driver inputs
    // --------------------------------------------------------------
    assign motor_ce   = pad[0];
    assign motor_word = pad[4:1];
endmodule : strap_board_model

/* File: sim/testbench.sv */
// Self-checking testbench for the reset strap sampler.
`timescale 1ns/1ns
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
    import strap_pkg::*;
    logic        ref_clk;
    logic        reset_n;
    logic [6:0]  pull_mask;
    logic [6:0]  pad;
    logic [6:0]  pin_out;
    logic [6:0]  pin_oe;
    logic        valid;
    logic        tm;
    logic        ai;
    logic        pe;
    logic [15:0] khz;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic        awvalid;
    logic        awready;
    logic        wvalid;
    logic        wready;
    logic        bvalid;
    logic        bready;
    logic        arvalid;
    logic        arready;
    logic        rvalid;
    logic        rready;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [3:0]  motor_word;
    logic        motor_ce;
    logic [12:0] ctrl_model;
    int          failures;
    int          n_tests;
    int          cycles;
    int          seed;

    reset_strap_sampler #(.ADDR_W(8)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .strap_pin_in(pad),
        .strap_pin_out(pin_out), .strap_pin_oe(pin_oe), .straps_valid(valid), .test_mode_request(tm),
        .flash_auto_init(ai), .flash_program_enable(pe), .pll_ref_khz(khz), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    strap_board_model board (.pull_mask(pull_mask), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad),
        .motor_word(motor_word), .motor_ce(motor_ce));

    // --------------------------------------------------------------
    // Clock, watchdog and verdict
    // --------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // The whole run needs about 600 cycles; a hung handshake ends here.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            end_sim();
        end
    end

    // --------------------------------------------------------------
    // Bus master and expectations
    // --------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    function automatic logic [6:0] exp_pins(input logic [12:0] c);
        logic [6:0] p;
        p = c[12:6];
        if (c[0]) begin
            p[0]   = c[1];
            p[4:1] = c[5:2];
        end
        return p;
    endfunction : exp_pins

    function automatic logic [31:0] exp_status(input logic [6:0] m);
        return {19'h0, m[6], m[4], ~m[4], |(m & TEST_MODE_MASK), 1'b1, 1'b0, m};
    endfunction : exp_status

    // --------------------------------------------------------------
    // One reset with a given strap fit, then pin driving
    // --------------------------------------------------------------
    task automatic run_case(input logic [6:0] m);
        logic [31:0] d;
        logic [31:0] wd;
        logic [3:0]  s;
        logic [1:0]  r;
        reset_n   <= 1'b0;
        pull_mask <= m;
        repeat (20) @(posedge ref_clk);
        `CHECK("oe in reset", 7'h00, pin_oe)
        `CHECK("auto init in reset", 1'b1, ai)
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHECK("oe", 7'h7f, pin_oe)
        `CHECK("valid", 1'b1, valid)
        `CHECK("test mode", |(m & TEST_MODE_MASK), tm)
        `CHECK("auto init", ~m[4], ai)
        `CHECK("program", m[4], pe)
        `CHECK("ref khz", m[6] ? PLL_REFERENCE_CLOCK_HIGH_KHZ : PLL_REFERENCE_CLOCK_LOW_KHZ, khz)
        axi_read(STATUS_OFFSET, d, r);
        `CHECK("status", exp_status(m), d)
        ctrl_model = 13'h0000;
        repeat (3) begin
            wd = $random(seed);
            s  = 4'($random(seed));
            axi_write(CTRL_OFFSET, wd, s, r);
            `CHECK("ctrl bresp", RESP_OKAY, r)
            if (s[0]) ctrl_model[7:0] = wd[7:0];
            if (s[1]) ctrl_model[12:8] = wd[12:8];
            repeat (2) @(posedge ref_clk);
            #1;
            `CHECK("pins", exp_pins(ctrl_model), pin_out)
            if (ctrl_model[0]) begin
                `CHECK("motor ce", ctrl_model[1], motor_ce)
                `CHECK("motor data", ctrl_model[5:2], motor_word)
            end
            axi_read(CTRL_OFFSET, d, r);
            `CHECK("ctrl", {19'h0, ctrl_model}, d)
        end
        axi_read(STATUS_OFFSET, d, r);
        `CHECK("status held", exp_status(m), d)
        `CHECK("test mode held", |(m & TEST_MODE_MASK), tm)
    endtask : run_case

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        seed = 15534;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        reset_n = 1'b0;
        pull_mask = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        run_case(7'h10);
        run_case(7'h40);
        run_case(7'h7f);
        run_case(7'h2f);
        repeat (6) run_case(7'($random(seed)));
        run_case(7'h00);
        axi_read(8'h08, d, r);
        `CHECK("unmapped rresp", RESP_SLVERR, r)
        `CHECK("unmapped rdata", 32'h0, d)
        axi_write(8'h0c, 32'hffffffff, 4'hf, r);
        `CHECK("unmapped bresp", RESP_SLVERR, r)
        axi_write(STATUS_OFFSET, 32'hffffffff, 4'hf, r);
        `CHECK("status bresp", RESP_OKAY, r)
        axi_read(STATUS_OFFSET, d, r);
        `CHECK("status ro", exp_status(7'h00), d)
        end_sim();
    end
endmodule : testbench
